// file: rtl/pato_pkg.sv
// package: constants and types for the phase alarm timeout block
package pato_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned STEP_S      = 2;                 // one timeout step, seconds
  localparam int unsigned STEP_CYC    = STEP_S * CLK_HZ;   // cycles per step
  localparam int unsigned AUTOCLR_S   = 128;               // auto-clear period, seconds
  localparam int unsigned AUTOCLR_STP = AUTOCLR_S / STEP_S;

  // ------------------------------------------------------------
  // register map (byte addresses; printed index times four)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_CFG     = 12'h0079;
  localparam logic [11:0] ADDR_CFG    = 12'(IDX_CFG * 4);
  localparam logic [11:0] ADDR_CTRL   = 12'h0200;
  localparam logic [11:0] ADDR_ALARM  = 12'h0204;
  localparam logic [11:0] ADDR_ACLR   = 12'h0208;
  localparam logic [11:0] ADDR_ISTAT  = 12'h020C;
  localparam logic [11:0] ADDR_ICLR   = 12'h0210;
  localparam logic [11:0] ADDR_IEN    = 12'h0214;
  localparam logic [11:0] ADDR_TICKS  = 12'h0218;

  localparam int          CFG_W       = 6;
  localparam logic [5:0]  CFG_RST     = 6'h32;
  localparam int          EV_W        = 2;
  localparam int          EV_RAISE    = 0;
  localparam int          EV_AUTOCLR  = 1;
  localparam int          CTRL_AUTOCLR = 0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_FREE      = 3'h0,
    LK_LOCKED    = 3'h1,
    LK_PRELOCK   = 3'h3,
    LK_PRELOCK2  = 3'h2,
    LK_PHASELOST = 3'h6
  } pato_lock_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_HUNT    = 2'h1,
    ST_EXPIRED = 2'h3
  } pato_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } pato_ahb_req_t;

endpackage

// file: rtl/pato_timeout.sv
// phase alarm timeout: lock-attempt timer, alarm flags, ahb-lite registers
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module pato_timeout
  import pato_pkg::*;
#(
  parameter int unsigned N_IN     = 8,
  parameter int unsigned STEP_CYC_P = STEP_CYC,
  parameter int unsigned AC_STEPS = AUTOCLR_STP
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire pato_ahb_req_t     ahb_req,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // primary dpll lock controller
  input  wire pato_lock_t        lock_state,
  input  wire logic [$clog2(N_IN)-1:0] sel_input,
  // alarms and interrupt
  output logic [N_IN-1:0]        phase_alarm,
  output logic                   irq
);

  localparam int SW = $clog2(N_IN);
  localparam logic [6:0] AC_LAST = 7'(AC_STEPS - 1);

  typedef struct packed {
    logic                   hready;
    logic [31:0]            hrdata;
    logic                   wr_pend;
    logic                   rd_pend;
    logic [11:0]            addr;
    logic [CFG_W-1:0]       cfg;
    logic                   ac_en;
    pato_state_t            state;
    logic [SW-1:0]          sel_q;
    logic [31:0]            pre;
    logic [CFG_W-1:0]       ticks;
    logic [31:0]            gpre;
    logic [N_IN-1:0]        alarm;
    logic [N_IN-1:0][6:0]   ac_cnt;
    logic [EV_W-1:0]        istat;
    logic [EV_W-1:0]        ien;
    logic                   irq;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_hunt(input pato_lock_t s);
    return (s == LK_PRELOCK) || (s == LK_PRELOCK2) || (s == LK_PHASELOST);
  endfunction

  function automatic logic [31:0] pad(input logic [31:0] v);
    return v;
  endfunction

  logic                hunting;
  logic                sel_moved;
  logic                addr_ph;
  logic                gtick;
  logic [N_IN-1:0]     sw_clr;
  logic [N_IN-1:0]     raise;

  assign hunting   = is_hunt(lock_state);
  assign sel_moved = sel_input != st_r.sel_q;
  assign addr_ph   = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign gtick     = st_r.gpre == STEP_CYC_P - 1;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    sw_clr  = '0;
    raise   = '0;
    st_nxt.sel_q = sel_input;
    st_nxt.gpre  = gtick ? '0 : st_r.gpre + 32'h0000_0001;

    // bus: reads take one wait state so a write just before is visible
    st_nxt.wr_pend = 1'b0;
    st_nxt.rd_pend = 1'b0;
    st_nxt.hready  = 1'b1;
    if (addr_ph) begin
      st_nxt.addr    = ahb_req.haddr[11:0];
      st_nxt.wr_pend = ahb_req.hwrite;
      st_nxt.rd_pend = !ahb_req.hwrite;
      st_nxt.hready  = ahb_req.hwrite;
    end
    if (st_r.rd_pend) begin
      unique case (st_r.addr)
        ADDR_CFG:   st_nxt.hrdata = pad({26'h0, st_r.cfg});
        ADDR_CTRL:  st_nxt.hrdata = pad({31'h0, st_r.ac_en});
        ADDR_ALARM: st_nxt.hrdata = pad(32'(st_r.alarm));
        ADDR_ISTAT: st_nxt.hrdata = pad({30'h0, st_r.istat});
        ADDR_IEN:   st_nxt.hrdata = pad({30'h0, st_r.ien});
        ADDR_TICKS: st_nxt.hrdata = pad({26'h0, st_r.ticks});
        default:    st_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    if (st_r.wr_pend) begin
      unique case (st_r.addr)
        ADDR_CFG:  st_nxt.cfg   = hwdata[CFG_W-1:0];
        ADDR_CTRL: st_nxt.ac_en = hwdata[CTRL_AUTOCLR];
        ADDR_ACLR: sw_clr       = hwdata[N_IN-1:0];
        ADDR_IEN:  st_nxt.ien   = hwdata[EV_W-1:0];
        default: ;
      endcase
    end

    // lock-attempt timer
    unique case (st_r.state)
      ST_IDLE: begin
        st_nxt.pre   = '0;
        st_nxt.ticks = '0;
        if (hunting) begin
          st_nxt.state = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (!hunting || sel_moved) begin
          st_nxt.state = ST_IDLE;
        end else if (st_r.ticks >= st_r.cfg) begin
          raise[st_r.sel_q] = 1'b1;
          st_nxt.state      = ST_EXPIRED;
        end else if (st_r.pre == STEP_CYC_P - 1) begin
          st_nxt.pre   = '0;
          st_nxt.ticks = st_r.ticks + 6'h01;
        end else begin
          st_nxt.pre = st_r.pre + 32'h0000_0001;
        end
      end
      ST_EXPIRED: begin
        // no further measurement of a rejected input
        if (!hunting || sel_moved) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase

    // alarms: a new raise wins over any clear in the same cycle
    for (int i = 0; i < N_IN; i++) begin
      if (raise[i]) begin
        st_nxt.alarm[i]  = 1'b1;
        st_nxt.ac_cnt[i] = '0;
      end else if (st_r.alarm[i]) begin
        if (sw_clr[i]) begin
          st_nxt.alarm[i] = 1'b0;
        end else if (st_r.ac_en && gtick) begin
          if (st_r.ac_cnt[i] == AC_LAST) begin
            st_nxt.alarm[i]           = 1'b0;
            st_nxt.istat[EV_AUTOCLR]  = 1'b1;
          end else begin
            st_nxt.ac_cnt[i] = st_r.ac_cnt[i] + 7'h01;
          end
        end
      end
    end
    if (|raise) begin
      st_nxt.istat[EV_RAISE] = 1'b1;
    end

    // interrupt status: clear first, then events set over it
    if (st_r.wr_pend && st_r.addr == ADDR_ICLR) begin
      st_nxt.istat = st_r.istat & ~hwdata[EV_W-1:0];
      if (|raise) st_nxt.istat[EV_RAISE] = 1'b1;
      for (int i = 0; i < N_IN; i++) begin
        if (!raise[i] && st_r.alarm[i] && !sw_clr[i] && st_r.ac_en && gtick && st_r.ac_cnt[i] == AC_LAST) begin
          st_nxt.istat[EV_AUTOCLR] = 1'b1;
        end
      end
    end
    st_nxt.irq = |(st_nxt.istat & st_nxt.ien);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r        <= '0;
      st_r.hready <= 1'b1;
      st_r.cfg    <= CFG_RST;
      st_r.state  <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout   = st_r.hready;
  assign hrdata      = st_r.hrdata;
  assign hresp       = 1'b0;
  assign phase_alarm = st_r.alarm;
  assign irq         = st_r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [N_IN-1:0] alarm_q;
  logic [N_IN-1:0] rose_q;
  logic [N_IN-1:0] fell_q;

  // previous alarm word for edge checks; reset value matches the reset alarm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= st_r.alarm;
    end
  end

  assign rose_q = st_r.alarm & ~alarm_q;
  assign fell_q = ~st_r.alarm & alarm_q;

  sequence left_hunt_s;
    st_r.state == ST_HUNT ##0 (!hunting || sel_moved);
  endsequence

  sequence cfg_write_s;
    st_r.wr_pend && st_r.addr == ADDR_CFG;
  endsequence

  only_selected_a: assert property (|rose_q |-> rose_q == N_IN'(1) << $past(st_r.sel_q) && $past(hunting))
    else $error("alarm raised on an input not under lock attempt");
  no_remeasure_a: assert property (st_r.state == ST_EXPIRED && hunting && !sel_moved |=> st_r.state == ST_EXPIRED)
    else $error("expired input measured again");
  cfg_write_a: assert property (cfg_write_s |=> st_r.cfg == $past(hwdata[CFG_W-1:0]))
    else $error("timeout field not written from low six bits");
  // re-entry from idle also changes ticks, so only steps within one hunt count
  step_count_a: assert property (st_r.state == ST_HUNT && $past(st_r.state) == ST_HUNT && st_nxt.state == ST_HUNT
                                 && st_r.ticks != $past(st_r.ticks) |-> $past(st_r.pre) == STEP_CYC_P - 1)
    else $error("timeout step advanced early");
  timeout_hit_a: assert property (|rose_q |-> $past(st_r.ticks) >= $past(st_r.cfg) && $past(st_r.state) == ST_HUNT)
    else $error("alarm raised before timeout elapsed");
  restart_timer_a: assert property (left_hunt_s |=> st_r.state == ST_IDLE ##1 st_r.ticks == '0 && st_r.pre == '0)
    else $error("timer not restarted after leaving hunt");
  persist_alarm_a: assert property (!$past(st_r.ac_en) && !($past(st_r.wr_pend) && $past(st_r.addr) == ADDR_ACLR) |-> fell_q == '0)
    else $error("alarm dropped without clear");
  irq_level_a: assert property (|rose_q && st_r.ien[EV_RAISE] |-> irq && st_r.istat[EV_RAISE])
    else $error("enabled alarm raise did not interrupt");
  // a read holds the bus for exactly one wait state
  read_wait_a: assert property (!st_r.hready |=> st_r.hready)
    else $error("read wait state longer than one cycle");

endmodule

// file: sim/tb_top.sv
// testbench: phase alarm timeout block, driven over ahb-lite
`timescale 1ns/100ps
module tb_top;
  import pato_pkg::*;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam int S  = 10;
  localparam int AC = 4;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  pato_ahb_req_t req = '0;
  pato_ahb_req_t bus;
  logic [31:0]   hwdata = '0;
  logic [31:0]   hrdata;
  logic [31:0]   st = 32'h2b80_23b5;
  logic          hreadyout;
  logic          hresp;
  logic          irq;
  pato_lock_t    lock_state = LK_FREE;
  logic [2:0]    sel = 3'h0;
  logic [7:0]    phase_alarm;
  logic [31:0]   expq[$];
  int            n_mismatch = 0;
  int            samples_checked = 0;
  int            n;
  bit            rd_ph = 1'b0;
  pato_lock_t    hs[3] = '{LK_PRELOCK, LK_PRELOCK2, LK_PHASELOST};

  always #5 hclk = ~hclk;
  always_comb begin
    bus = req;
    bus.hready = hreadyout;
  end

  pato_timeout #(.N_IN(8), .STEP_CYC_P(S), .AC_STEPS(AC)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(bus), .hwdata(hwdata), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .lock_state(lock_state), .sel_input(sel),
    .phase_alarm(phase_alarm), .irq(irq));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for hready, sampled at the rising edge
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    req.hsel   <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr  <= {20'h0_0000, a};
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    rdy();
    req.hsel   <= 1'b0;
    req.htrans <= 2'b00;
    hwdata     <= d;
    rdy();
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // read result is noted here and judged by the monitor
  task automatic rd(logic [11:0] a, logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // hold a lock state and count edges until any alarm shows
  task automatic hunt(pato_lock_t ls, logic [2:0] s, int lim, bit must);
    lock_state <= ls;
    sel        <= s;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (phase_alarm === 8'h00 && n < lim);
    if (must && n >= lim) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic idle_clear();
    lock_state <= LK_FREE;
    wr(ADDR_ACLR, 32'h0000_00ff);
    wr(ADDR_ICLR, 32'h0000_0003);
  endtask

  // ----------------------------------------
  // read monitor and main sequence
  // ----------------------------------------
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      chk(hrdata, (expq.size() > 0) ? expq.pop_front() : 32'hdead_beef, "read data");
      chk(hresp, 0, "okay response");
      rd_ph = 1'b0;
    end
    if (bus.hsel && bus.htrans[1] && hreadyout && !bus.hwrite) rd_ph = 1'b1;
  end

  initial begin
    int c;
    logic [2:0] s;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADDR_CFG, 32'h0000_0032);
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(12'hff0, 32'h0000_0000);
    wr(ADDR_CFG, 32'h0000_00ff);
    rd(ADDR_CFG, 32'h0000_003f);
    $display("test registers done");
    wr(ADDR_IEN, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      c = int'(rnd() % 3) + 1;
      s = rnd() % 8;
      wr(ADDR_CFG, c);
      hunt(hs[i], s, 200, 1'b1);
      chk(n >= c * S && n <= c * S + 5, 1, "alarm delay");
      chk(phase_alarm, 32'h1 << s, "alarm input");
      repeat (2) @(posedge hclk);
      chk(irq, 1, "irq raised");
      rd(ADDR_ISTAT, 32'h0000_0001);
      wr(ADDR_ACLR, 32'h0000_00ff);
      wr(ADDR_ICLR, 32'h0000_0003);
      hunt(hs[i], s, 3 * c * S, 1'b0);
      chk(phase_alarm, 0, "no re-alarm");
      chk(irq, 0, "irq cleared");
      lock_state <= LK_FREE;
      repeat (2) @(posedge hclk);
    end
    $display("test hunting states done");
    wr(ADDR_CFG, 32'h0000_0002);
    wr(ADDR_IEN, 32'h0000_0000);
    hunt(LK_PRELOCK, 3'h1, 15, 1'b0);
    hunt(LK_PRELOCK, 3'h5, 200, 1'b1);
    chk(n >= 2 * S && n <= 2 * S + 5, 1, "restart on input");
    chk(phase_alarm, 32'h20, "new input only");
    repeat (3) @(posedge hclk);
    chk(irq, 0, "irq masked");
    rd(ADDR_ISTAT, 32'h0000_0001);
    idle_clear();
    hunt(LK_LOCKED, 3'h2, 100, 1'b0);
    chk(phase_alarm, 0, "locked no alarm");
    hunt(LK_PRELOCK, 3'h2, 15, 1'b0);
    hunt(LK_LOCKED, 3'h2, 3, 1'b0);
    hunt(LK_PRELOCK, 3'h2, 200, 1'b1);
    chk(n >= 2 * S && n <= 2 * S + 5, 1, "restart on leave");
    idle_clear();
    $display("test restart done");
    wr(ADDR_CFG, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0001);
    hunt(LK_PHASELOST, 3'h3, 200, 1'b1);
    lock_state <= LK_FREE;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (phase_alarm !== 8'h00 && n < 200);
    chk(n >= (AC - 1) * S && n <= AC * S + 5, 1, "auto-clear time");
    rd(ADDR_ISTAT, 32'h0000_0003);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_ICLR, 32'h0000_0003);
    hunt(LK_PRELOCK2, 3'h4, 200, 1'b1);
    lock_state <= LK_FREE;
    repeat (2 * AC * S) @(posedge hclk);
    chk(phase_alarm, 32'h10, "alarm persists");
    rd(ADDR_ALARM, 32'h0000_0010);
    $display("test auto-clear done");
    repeat (4) @(posedge hclk);
    results();
  end
endmodule
